/* File: shared/rmit_pkg.sv */
// shared types and constants for the register move timing decoder
package rmit_pkg;

	localparam int unsigned OP_W = 6;
	localparam int unsigned BYTES_W = 3;
	localparam int unsigned STATES_W = 7;
	localparam int unsigned WAIT_W = 4;
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned DATA_W = 32;

	// source mode saves one opcode byte and one state on every form
	localparam logic [BYTES_W-1:0] SRC_BYTE_SAVE = 3'h1;
	localparam logic [STATES_W-1:0] SRC_STATE_SAVE = 7'h01;

	// extra states for short direct targets
	localparam logic [STATES_W-1:0] PORT_EXTRA = 7'h01;
	localparam logic [STATES_W-1:0] SFR_EXTRA = 7'h02;

	// external memory extras: byte N+2, word 2(N+1), dword 4(N+2)
	localparam logic [STATES_W-1:0] EXT_BYTE_ADD = 7'h02;
	localparam logic [STATES_W-1:0] EXT_WORD_ADD = 7'h01;
	localparam logic [STATES_W-1:0] EXT_DWORD_ADD = 7'h02;
	localparam int unsigned EXT_WORD_SHIFT = 1;
	localparam int unsigned EXT_DWORD_SHIFT = 2;

	// region masks
	localparam logic [ADDR_W-1:0] REGION_64K_MASK = 24'h00FFFF;
	localparam logic [ADDR_W-1:0] REGION_16M_MASK = 24'hFFFFFF;
	localparam logic [ADDR_W-1:0] SHORT_DIR_MASK = 24'h0000FF;

	localparam logic [15:0] UPPER_ZERO = 16'h0000;
	localparam logic [15:0] UPPER_ONES = 16'hFFFF;

	typedef enum logic [OP_W-1:0] {
		OP_MV_B, OP_MV_W, OP_MV_D,
		OP_LI_B, OP_LI_W, OP_LI_DZ, OP_LI_DO,
		OP_LDS_B, OP_LDS_W, OP_LDS_D,
		OP_LDL_B, OP_LDL_W, OP_LDL_D,
		OP_LDI_BW, OP_LDI_BD, OP_LDI_WW, OP_LDI_WD,
		OP_STS_B, OP_STS_W, OP_STS_D,
		OP_STL_B, OP_STL_W, OP_STL_D,
		OP_STI_BW, OP_STI_BD, OP_STI_WW, OP_STI_WD,
		OP_LDX_BW, OP_LDX_WW, OP_LDX_BD, OP_LDX_WD,
		OP_STX_BW, OP_STX_WW, OP_STX_BD, OP_STX_WD
	} rmit_op_t;

	typedef enum logic [1:0] {
		TGT_ONCHIP = 2'h0,
		TGT_PORT = 2'h1,
		TGT_SFR = 2'h2,
		TGT_EXTERNAL = 2'h3
	} rmit_target_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_DWORD = 2'h2
	} rmit_size_t;

	typedef enum logic [2:0] {
		ACC_REG = 3'h0,
		ACC_IMM = 3'h1,
		ACC_SHORT = 3'h2,
		ACC_LONG = 3'h3,
		ACC_IND = 3'h4,
		ACC_DISP = 3'h5
	} rmit_access_t;

	typedef struct packed {
		rmit_op_t op;
		rmit_target_t target;
		logic [DATA_W-1:0] pointer;
		logic [ADDR_W-1:0] displacement;
		logic [15:0] direct_address;
		logic [15:0] immediate;
		logic [DATA_W-1:0] source_data;
	} rmit_req_t;

	typedef struct packed {
		logic [BYTES_W-1:0] bytes;
		logic [STATES_W-1:0] states;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] data;
	} rmit_res_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_DONE = 3'h4
	} rmit_state_t;

endpackage

/* File: rtl/rmit_decoder.sv */
// register move timing decoder: length, state count, address and data
`timescale 1ns/10ps
module rmit_decoder (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic req_valid_i,
	input wire rmit_pkg::rmit_req_t req_i,
	input wire logic source_mode_i,
	input wire logic [rmit_pkg::WAIT_W-1:0] wait_states_i,
	output logic ready_o,
	output logic done_o,
	output rmit_pkg::rmit_res_t res_o
);
	import rmit_pkg::*;

	rmit_state_t state_reg;
	rmit_state_t state_next;
	logic [STATES_W-1:0] count_reg;
	rmit_res_t res_reg;
	rmit_res_t res_next;
	logic [BYTES_W-1:0] bin_bytes;
	logic [STATES_W-1:0] bin_states;
	rmit_size_t op_size;
	rmit_access_t op_access;
	logic wide_pointer;
	logic [STATES_W-1:0] wait_ext;
	logic [STATES_W-1:0] extra_states;
	logic [STATES_W-1:0] total_states;
	logic [BYTES_W-1:0] total_bytes;
	logic [ADDR_W-1:0] ptr_sum;
	logic take;

	assign take = req_valid_i && (state_reg == ST_IDLE);
	assign ready_o = (state_reg == ST_IDLE);
	assign done_o = (state_reg == ST_DONE);
	assign res_o = res_reg;

	// binary-mode base length and states per form
	always_comb begin
		bin_bytes = 3'h3;
		bin_states = 7'h02;
		op_size = SZ_BYTE;
		op_access = ACC_REG;
		wide_pointer = 1'b0;
		case (req_i.op)
			OP_MV_B: begin
				bin_states = 7'h02;
			end
			OP_MV_W: begin
				op_size = SZ_WORD;
				bin_states = 7'h02;
			end
			OP_MV_D: begin
				op_size = SZ_DWORD;
				bin_states = 7'h03;
			end
			OP_LI_B: begin
				op_access = ACC_IMM;
				bin_bytes = 3'h4;
				bin_states = 7'h03;
			end
			OP_LI_W: begin
				op_access = ACC_IMM;
				op_size = SZ_WORD;
				bin_bytes = 3'h5;
				bin_states = 7'h03;
			end
			OP_LI_DZ, OP_LI_DO: begin
				op_access = ACC_IMM;
				op_size = SZ_DWORD;
				bin_bytes = 3'h5;
				bin_states = 7'h05;
			end
			OP_LDS_B, OP_LDS_W, OP_LDS_D: begin
				op_access = ACC_SHORT;
				bin_bytes = 3'h4;
				bin_states = 7'h03;
				if (req_i.op == OP_LDS_W) begin
					op_size = SZ_WORD;
					bin_states = 7'h04;
				end else if (req_i.op == OP_LDS_D) begin
					op_size = SZ_DWORD;
					bin_states = 7'h06;
				end
			end
			OP_LDL_B, OP_LDL_W, OP_LDL_D: begin
				op_access = ACC_LONG;
				bin_bytes = 3'h5;
				bin_states = 7'h03;
				if (req_i.op == OP_LDL_W) begin
					op_size = SZ_WORD;
					bin_states = 7'h04;
				end else if (req_i.op == OP_LDL_D) begin
					op_size = SZ_DWORD;
					bin_states = 7'h06;
				end
			end
			OP_LDI_BW, OP_LDI_BD, OP_LDI_WW, OP_LDI_WD: begin
				op_access = ACC_IND;
				bin_bytes = 3'h4;
				bin_states = 7'h03;
				if (req_i.op == OP_LDI_BD) begin
					wide_pointer = 1'b1;
					bin_states = 7'h04;
				end else if (req_i.op == OP_LDI_WW) begin
					op_size = SZ_WORD;
					bin_states = 7'h04;
				end else if (req_i.op == OP_LDI_WD) begin
					op_size = SZ_WORD;
					wide_pointer = 1'b1;
					bin_states = 7'h05;
				end
			end
			OP_STS_B, OP_STS_W, OP_STS_D: begin
				op_access = ACC_SHORT;
				bin_bytes = 3'h4;
				bin_states = 7'h04;
				if (req_i.op == OP_STS_W) begin
					op_size = SZ_WORD;
					bin_states = 7'h05;
				end else if (req_i.op == OP_STS_D) begin
					op_size = SZ_DWORD;
					bin_states = 7'h07;
				end
			end
			OP_STL_B, OP_STL_W, OP_STL_D: begin
				op_access = ACC_LONG;
				bin_bytes = 3'h5;
				bin_states = 7'h04;
				if (req_i.op == OP_STL_W) begin
					op_size = SZ_WORD;
					bin_states = 7'h05;
				end else if (req_i.op == OP_STL_D) begin
					op_size = SZ_DWORD;
					bin_states = 7'h07;
				end
			end
			OP_STI_BW, OP_STI_BD, OP_STI_WW, OP_STI_WD: begin
				op_access = ACC_IND;
				bin_bytes = 3'h4;
				bin_states = 7'h04;
				if (req_i.op == OP_STI_BD) begin
					wide_pointer = 1'b1;
					bin_states = 7'h05;
				end else if (req_i.op == OP_STI_WW) begin
					op_size = SZ_WORD;
					bin_states = 7'h05;
				end else if (req_i.op == OP_STI_WD) begin
					op_size = SZ_WORD;
					wide_pointer = 1'b1;
					bin_states = 7'h06;
				end
			end
			OP_LDX_BW, OP_LDX_WW, OP_LDX_BD, OP_LDX_WD: begin
				op_access = ACC_DISP;
				bin_bytes = 3'h5;
				bin_states = 7'h06;
				if (req_i.op == OP_LDX_WW) begin
					op_size = SZ_WORD;
					bin_states = 7'h07;
				end else if (req_i.op == OP_LDX_BD) begin
					wide_pointer = 1'b1;
					bin_states = 7'h07;
				end else if (req_i.op == OP_LDX_WD) begin
					op_size = SZ_WORD;
					wide_pointer = 1'b1;
					bin_states = 7'h08;
				end
			end
			OP_STX_BW, OP_STX_WW, OP_STX_BD, OP_STX_WD: begin
				op_access = ACC_DISP;
				bin_bytes = 3'h5;
				bin_states = 7'h06;
				if (req_i.op == OP_STX_WW) begin
					op_size = SZ_WORD;
					bin_states = 7'h07;
				end else if (req_i.op == OP_STX_BD) begin
					wide_pointer = 1'b1;
					bin_states = 7'h07;
				end else if (req_i.op == OP_STX_WD) begin
					op_size = SZ_WORD;
					wide_pointer = 1'b1;
					bin_states = 7'h08;
				end
			end
			default: begin
				bin_bytes = 3'h3;
				bin_states = 7'h02;
			end
		endcase
	end

	// external memory penalty by operand size
	always_comb begin
		wait_ext = 7'h00;
		case (op_size)
			SZ_BYTE: begin
				wait_ext = {3'h0, wait_states_i} + EXT_BYTE_ADD;
			end
			SZ_WORD: begin
				wait_ext = 7'(({3'h0, wait_states_i} + EXT_WORD_ADD) << EXT_WORD_SHIFT);
			end
			SZ_DWORD: begin
				wait_ext = 7'(({3'h0, wait_states_i} + EXT_DWORD_ADD) << EXT_DWORD_SHIFT);
			end
			default: begin
				wait_ext = 7'h00;
			end
		endcase
	end

	// target dependent extra states
	always_comb begin
		extra_states = 7'h00;
		if (op_access == ACC_SHORT) begin
			if (req_i.target == TGT_PORT) begin
				extra_states = PORT_EXTRA;
			end else if (req_i.target == TGT_SFR) begin
				extra_states = SFR_EXTRA;
			end
		end else if (op_access == ACC_LONG || op_access == ACC_IND || op_access == ACC_DISP) begin
			if (req_i.target == TGT_EXTERNAL) begin
				extra_states = wait_ext;
			end
		end
	end

	// mode applies the same saving to every form
	always_comb begin
		total_bytes = bin_bytes;
		total_states = bin_states + extra_states;
		if (source_mode_i) begin
			total_bytes = bin_bytes - SRC_BYTE_SAVE;
			total_states = bin_states - SRC_STATE_SAVE + extra_states;
		end
	end

	// effective address and region wrap
	always_comb begin
		ptr_sum = 24'h000000;
		case (op_access)
			ACC_SHORT: begin
				ptr_sum = {8'h00, req_i.direct_address} & SHORT_DIR_MASK;
			end
			ACC_LONG: begin
				ptr_sum = {8'h00, req_i.direct_address} & REGION_64K_MASK;
			end
			ACC_IND: begin
				if (wide_pointer) begin
					ptr_sum = req_i.pointer[ADDR_W-1:0] & REGION_16M_MASK;
				end else begin
					ptr_sum = req_i.pointer[ADDR_W-1:0] & REGION_64K_MASK;
				end
			end
			ACC_DISP: begin
				if (wide_pointer) begin
					ptr_sum = (req_i.pointer[ADDR_W-1:0] + req_i.displacement)
						& REGION_16M_MASK;
				end else begin
					ptr_sum = ({8'h00, req_i.pointer[15:0]}
						+ {8'h00, req_i.displacement[15:0]})
						& REGION_64K_MASK;
				end
			end
			default: begin
				ptr_sum = 24'h000000;
			end
		endcase
	end

	// result word captured at acceptance
	always_comb begin
		res_next.bytes = total_bytes;
		res_next.states = total_states;
		res_next.address = ptr_sum;
		res_next.data = req_i.source_data;
		case (req_i.op)
			OP_LI_B: begin
				res_next.data = {24'h000000, req_i.immediate[7:0]};
			end
			OP_LI_W: begin
				res_next.data = {UPPER_ZERO, req_i.immediate};
			end
			OP_LI_DZ: begin
				res_next.data = {UPPER_ZERO, req_i.immediate};
			end
			OP_LI_DO: begin
				res_next.data = {UPPER_ONES, req_i.immediate};
			end
			default: begin
				if (op_size == SZ_BYTE) begin
					res_next.data = {24'h000000, req_i.source_data[7:0]};
				end else if (op_size == SZ_WORD) begin
					res_next.data = {UPPER_ZERO, req_i.source_data[15:0]};
				end
			end
		endcase
	end

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (count_reg == 7'h01) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// one clock per state of the instruction
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_reg <= 7'h00;
		end else if (take) begin
			count_reg <= total_states;
		end else if (state_reg == ST_EXEC) begin
			count_reg <= count_reg - 7'h01;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			res_reg <= '0;
		end else if (take) begin
			res_reg <= res_next;
		end
	end

endmodule

/* File: verification/rmit_decoder_assertions.sv */
// concurrent checks on the register move timing decoder ports
`timescale 1ns/10ps
module rmit_decoder_assertions (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic req_valid_i,
	input wire rmit_pkg::rmit_req_t req_i,
	input wire logic source_mode_i,
	input wire logic [rmit_pkg::WAIT_W-1:0] wait_states_i,
	input wire logic ready_o,
	input wire logic done_o,
	input wire rmit_pkg::rmit_res_t res_o
);
	import rmit_pkg::*;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic take = req_valid_i && ready_o;
	wire logic bin = take && !source_mode_i;
	AST_TAKE_BUSY: assert property (take |=> !ready_o)
		else $error("ready stayed high after a take");
	AST_BUSY_HOLD: assert property (!ready_o |=> $stable(res_o))
		else $error("result changed while busy");
	AST_DONE_ONE: assert property (done_o |=> !done_o && ready_o)
		else $error("done not a single pulse followed by idle");
	AST_MV_B_TIME: assert property (bin && req_i.op == OP_MV_B |=> !done_o [*2] ##1 done_o)
		else $error("byte move did not finish after two states");
	AST_MV_D_SRC: assert property (take && source_mode_i && req_i.op == OP_MV_D
		|=> res_o.bytes == 3'h2 && res_o.states == 7'h02)
		else $error("dword move source length or states wrong");
	AST_LI_W_SRC: assert property (take && source_mode_i && req_i.op == OP_LI_W
		|=> res_o.bytes == 3'h4 && res_o.states == 7'h02)
		else $error("word immediate source length or states wrong");
	AST_FILL_ZERO: assert property (take && req_i.op == OP_LI_DZ
		|=> res_o.data == {16'h0000, $past(req_i.immediate)})
		else $error("zero fill wrong");
	AST_FILL_ONES: assert property (take && req_i.op == OP_LI_DO
		|=> res_o.data == {16'hFFFF, $past(req_i.immediate)})
		else $error("ones fill wrong");
	AST_SFR_EXTRA: assert property (bin && req_i.op == OP_LDS_B && req_i.target == TGT_SFR
		|=> res_o.states == 7'h05)
		else $error("sfr extra states wrong");
	AST_EXT_BYTE: assert property (bin && req_i.op == OP_LDL_B && req_i.target == TGT_EXTERNAL
		|=> res_o.states == 7'($past(wait_states_i)) + 7'h05)
		else $error("external byte extra states wrong");
	AST_EXT_WORD: assert property (bin && req_i.op == OP_LDL_W && req_i.target == TGT_EXTERNAL
		|=> res_o.states == 7'h04 + (7'($past(wait_states_i)) + 7'h01) * 7'h02)
		else $error("external word extra states wrong");
	AST_EXT_DWORD: assert property (bin && req_i.op == OP_LDL_D && req_i.target == TGT_EXTERNAL
		|=> res_o.states == 7'h06 + (7'($past(wait_states_i)) + 7'h02) * 7'h04)
		else $error("external dword extra states wrong");
endmodule

/* File: verification/rmit_wait_model.sv */
// external memory side model: holds the programmed wait-state count
`timescale 1ns/10ps
module rmit_wait_model (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [rmit_pkg::WAIT_W-1:0] setting_i,
	output logic [rmit_pkg::WAIT_W-1:0] wait_states_o
);
	import rmit_pkg::*;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_states_o <= '0;
		end else begin
			wait_states_o <= setting_i;
		end
	end
endmodule

/* File: verification/testbench.sv */
// self-checking testbench for the register move timing decoder
`timescale 1ns/10ps
module testbench;
	import rmit_pkg::*;
	localparam int BB[35] = '{3,3,3,4,5,5,5,4,4,4,5,5,5,4,4,4,4,4,4,4,5,5,5,4,4,4,4,5,5,5,5,5,5,5,5};
	localparam int BS[35] = '{2,2,3,3,3,5,5,3,4,6,3,4,6,3,4,4,5,4,5,7,4,5,7,4,5,5,6,6,7,7,8,6,7,7,8};
	localparam int SZ[35] = '{0,1,2,0,1,2,2,0,1,2,0,1,2,0,0,1,1,0,1,2,0,1,2,0,0,1,1,0,1,0,1,0,1,0,1};
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic source_mode_i = 1'b0;
	logic [3:0] cfg = 4'h0;
	logic [WAIT_W-1:0] wait_states;
	rmit_req_t req_i = '0;
	rmit_req_t r = '0;
	logic ready_o;
	logic done_o;
	rmit_res_t res_o;
	int errors = 0;
	int n_compared = 0;
	always #2 clock_i = ~clock_i;
	rmit_wait_model u_mem (.clock_i(clock_i), .nrst_i(nrst_i), .setting_i(cfg),
		.wait_states_o(wait_states));
	rmit_decoder u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .source_mode_i(source_mode_i), .wait_states_i(wait_states),
		.ready_o(ready_o), .done_o(done_o), .res_o(res_o));
	function automatic int ex(int o, rmit_target_t t, logic sm, int n);
		int s;
		s = BS[o] - int'(sm);
		if ((o >= 7 && o <= 9) || (o >= 17 && o <= 19)) begin
			s += (t == TGT_PORT) ? 1 : (t == TGT_SFR) ? 2 : 0;
		end else if (o >= 10 && t == TGT_EXTERNAL) begin
			s += (SZ[o] == 0) ? n + 2 : (SZ[o] == 1) ? 2 * (n + 1) : 4 * (n + 2);
		end
		return s;
	endfunction
	task automatic ck(input logic [65:0] g, input logic [65:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic go(input int o, input rmit_target_t t, input logic sm, input int n);
		int c;
		@(posedge clock_i);
		cfg <= 4'(n);
		r.op = rmit_op_t'(o);
		r.target = t;
		@(posedge clock_i);
		req_i <= r;
		source_mode_i <= sm;
		req_valid_i <= 1'b1;
		@(posedge clock_i);
		req_valid_i <= 1'b0;
		c = 0;
		do begin
			@(posedge clock_i);
			#1;
			c++;
		end while (done_o !== 1'b1 && c < 200);
		ck(66'(c), 66'(ex(o, t, sm, n)));
		ck(66'(res_o.states), 66'(ex(o, t, sm, n)));
		ck(66'(res_o.bytes), 66'(BB[o] - int'(sm)));
	endtask
	task automatic t_base;
		for (int o = 0; o < 35; o++) begin
			go(o, TGT_ONCHIP, 1'b0, 0);
			go(o, TGT_ONCHIP, 1'b1, 0);
		end
		$display("test base done");
	endtask
	task automatic t_tgt;
		for (int o = 0; o < 35; o++) begin
			for (int t = 1; t < 4; t++) begin
				go(o, rmit_target_t'(t), 1'b0, 15);
				go(o, rmit_target_t'(t), 1'b1, 6);
			end
		end
		$display("test targets done");
	endtask
	task automatic t_data;
		r.immediate = 16'h8001;
		go(OP_LI_DZ, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.data), 66'h00008001);
		go(OP_LI_DO, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.data), 66'hFFFF8001);
		r.pointer = 32'h0001FFF0;
		r.displacement = 24'h000020;
		go(OP_LDX_WW, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h000010);
		go(OP_LDX_WD, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h020010);
		r.source_data = 32'h12345678;
		r.direct_address = 16'h1234;
		go(OP_LI_B, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.data), 66'h00000001);
		go(OP_MV_W, TGT_ONCHIP, 1'b1, 0);
		ck(66'(res_o.data), 66'h00005678);
		go(OP_LDS_B, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h000034);
		go(OP_LDL_W, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h001234);
		go(OP_LDI_BW, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h00FFF0);
		go(OP_LDI_BD, TGT_ONCHIP, 1'b0, 0);
		ck(66'(res_o.address), 66'h01FFF0);
		$display("test data done");
	endtask
	task automatic t_refuse;
		@(posedge clock_i);
		r.op = OP_MV_D;
		req_i <= r;
		source_mode_i <= 1'b0;
		req_valid_i <= 1'b1;
		@(posedge clock_i);
		r.op = OP_LI_B;
		req_i <= r;
		repeat (3) @(posedge clock_i);
		req_valid_i <= 1'b0;
		#1;
		ck(66'(done_o), 66'h1);
		ck(66'(res_o.states), 66'h3);
		repeat (2) @(posedge clock_i);
		#1;
		ck(66'(ready_o), 66'h1);
		ck(66'(res_o.bytes), 66'h3);
		$display("test refuse done");
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		#1;
		ck(66'(ready_o), 66'h1);
		ck(66'(res_o), 66'h0);
		t_base();
		t_tgt();
		t_data();
		t_refuse();
		end_of_test();
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
bind rmit_decoder rmit_decoder_assertions u_chk (.clock_i(clock_i), .nrst_i(nrst_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .source_mode_i(source_mode_i),
	.wait_states_i(wait_states_i), .ready_o(ready_o), .done_o(done_o), .res_o(res_o));
